// ### core/rcr_pkg.sv
// Purpose: shared constants for the regulator control register bank
// Assumes: byte address of a register is four times its index
// Notes:   one control byte layout shared by all four regulators
package rcr_pkg;
   localparam int NUM_LDO    = 4;
   localparam int REG_W      = 8;
   localparam int GPIO_N     = 3;
   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_REG8  = 8'h2D;
   localparam logic [7:0] IDX_REG9  = 8'h2E;
   localparam logic [7:0] IDX_REG10 = 8'h2F;
   localparam logic [7:0] IDX_REG11 = 8'h30;
   localparam logic [7:0] IDX_VIB   = 8'h31;
   // ----------------------------------------------------------------
   // control byte fields
   // ----------------------------------------------------------------
   localparam int BIT_SEQ_TGT = 7;
   localparam int VS_SRC_HI   = 6;
   localparam int VS_SRC_LO   = 5;
   localparam int BIT_VSEL    = 4;
   localparam int BIT_PD_DIS  = 3;
   localparam int EN_SRC_HI   = 2;
   localparam int EN_SRC_LO   = 1;
   localparam int BIT_EN      = 0;
   localparam int VIB_CODE_HI = 5;
   localparam int VIB_CODE_W  = 6;
   // ----------------------------------------------------------------
   // reset values and gpio source codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] VIB_RST = 8'h00;
   localparam logic [1:0] SRC_SEQ    = 2'h0;
   localparam logic [1:0] SRC_GPIO1  = 2'h1;
   localparam logic [1:0] SRC_GPIO2  = 2'h2;
   localparam logic [1:0] SRC_GPIO13 = 2'h3;
   // pwm period in clocks: 63 steps of 3 V / 63
   localparam logic [5:0] VIB_PERIOD = 6'h3F;

   // level of the gpio that a source field names, 0 for the sequencer
   function automatic logic src_bit(logic [1:0] src, logic [2:0] v);
      case (src)
         SRC_GPIO1:  return v[0];
         SRC_GPIO2:  return v[1];
         SRC_GPIO13: return v[2];
         default:    return 1'b0;
      endcase
   endfunction
endpackage

// ### core/rcr_upd_if.sv
// Purpose: hardware update requests for one regulator control byte
// Assumes: requests are one-cycle, same clock as the register
// Notes:   source is the per-regulator decoder, sink is the bank
interface rcr_upd_if;
   logic en_upd;
   logic en_val;
   logic vs_upd;
   logic vs_val;
   modport src (output en_upd, output en_val, output vs_upd,
                output vs_val);
   modport dst (input en_upd, input en_val, input vs_upd, input vs_val);
endinterface

// ### core/rcr_ldo_ctl.sv
// Purpose: decode gpio and sequencer control of one regulator
// Assumes: gpio levels are synchronised, active high
// Notes:   purely combinational, bank applies the requests
module rcr_ldo_ctl (
   input  wire logic [7:0] ctl,
   input  wire logic [2:0] gpio_lvl,
   input  wire logic [2:0] gpio_prv,
   input  wire logic       seq_apply,
   rcr_upd_if.src          upd
);
   logic [1:0] en_src;
   logic [1:0] vs_src;
   logic       en_now;
   logic       en_was;
   logic       vs_now;
   logic       vs_was;

   // ----------------------------------------------------------------
   // source decode
   // ----------------------------------------------------------------
   assign en_src = ctl[rcr_pkg::EN_SRC_HI:rcr_pkg::EN_SRC_LO];
   assign vs_src = ctl[rcr_pkg::VS_SRC_HI:rcr_pkg::VS_SRC_LO];
   assign en_now = rcr_pkg::src_bit(en_src, gpio_lvl); // RULE3
   assign en_was = rcr_pkg::src_bit(en_src, gpio_prv); // RULE3
   assign vs_now = rcr_pkg::src_bit(vs_src, gpio_lvl); // RULE3
   assign vs_was = rcr_pkg::src_bit(vs_src, gpio_prv); // RULE3

   // ----------------------------------------------------------------
   // update requests
   // ----------------------------------------------------------------
   always_comb begin
      upd.en_upd = 1'b0;
      upd.en_val = 1'b0;
      if (en_src == rcr_pkg::SRC_SEQ) begin
         upd.en_upd = seq_apply; // RULE1
         upd.en_val = ctl[rcr_pkg::BIT_SEQ_TGT]; // RULE1
      end else begin
         upd.en_upd = en_now ^ en_was; // RULE6
         upd.en_val = en_now; // RULE6
      end
   end

   // rising edge picks setting a (0), falling edge setting b (1)
   assign upd.vs_upd = (vs_src != rcr_pkg::SRC_SEQ) && (vs_now ^ vs_was); // RULE2
   assign upd.vs_val = ~vs_now; // RULE2
endmodule // rcr_ldo_ctl

// ### core/rcr_vib_drv.sv
// Purpose: pwm drive of the vibration motor output stage
// Assumes: one pwm period is 63 clocks
// Notes:   level code is taken at the start of each period
module rcr_vib_drv (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [5:0] code,
   output logic            pmos_on_ff,
   output logic            nmos_on_ff
);
   logic [5:0] cnt_ff;
   logic [5:0] code_lat_ff;
   logic [5:0] hi_acc_ff;
   logic       hi_now;

   // ----------------------------------------------------------------
   // period counter and code latch
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 6'h00;
      end else if (cnt_ff == rcr_pkg::VIB_PERIOD - 6'h01) begin
         cnt_ff <= 6'h00;
      end else begin
         cnt_ff <= cnt_ff + 6'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_lat_ff <= 6'h00;
      end else if (cnt_ff == rcr_pkg::VIB_PERIOD - 6'h01) begin
         code_lat_ff <= code;
      end
   end

   // ----------------------------------------------------------------
   // output stage, code 0 brakes: low side on, high side off
   // ----------------------------------------------------------------
   assign hi_now = (code_lat_ff != 6'h00) && (cnt_ff < code_lat_ff); // RULE9

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pmos_on_ff <= 1'b0;
         nmos_on_ff <= 1'b1;
      end else begin
         pmos_on_ff <= hi_now; // RULE8
         nmos_on_ff <= ~hi_now; // RULE8
      end
   end

   // high cycles seen in the current period, for checking only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_acc_ff <= 6'h00;
      end else if (cnt_ff == 6'h00) begin
         hi_acc_ff <= {5'h00, hi_now};
      end else begin
         hi_acc_ff <= hi_acc_ff + {5'h00, hi_now};
      end
   end

   a_vib_brake_state: assert property (@(posedge hclk) disable iff (!hresetn)
      code_lat_ff == 6'h00 |=> nmos_on_ff && !pmos_on_ff) // RULE8
      else $error("brake state not driven for code zero");

   a_vib_duty_count: assert property (@(posedge hclk) disable iff (!hresetn)
      cnt_ff == rcr_pkg::VIB_PERIOD - 6'h01 |->
         hi_acc_ff + {5'h00, hi_now} == code_lat_ff) // RULE9
      else $error("pwm high time differs from level code");
endmodule // rcr_vib_drv

// ### core/rcr_regs.sv
// Purpose: control registers of regulators 8 to 11 and vibration level
// Assumes: ahb-lite slave, zero wait states, gpio pins are asynchronous
// Notes:   hardware updates of a control bit win over a same-cycle write
//
// The AHB-Lite register port is this design's own decision.

// Functional notes
// RULE1: sequencer run copies bit 7 into the enable bit.
// RULE2: voltage gpio rising selects setting a, falling selects setting b.
// RULE3: gpio source codes: 00 sequencer, 01 gpio1, 10 gpio2, 11 gpio13.
// RULE4: bit 4 picks the active voltage setting, 0 a, 1 b, at once.
// RULE5: bit 3 zero connects pull-down while disabled; one leaves it off.
// RULE6: enable gpio rising enables the regulator, falling disables it.
// RULE7: bit 0 directly disables (0) or enables (1) the regulator.
// RULE8: vibration code zero brakes: low side on, high side off.
// RULE9: nonzero vibration codes set average level in steps of 3 V / 63.
// RULE10: vibration bits 7:6 are plain storage; all fields read back.
module rcr_regs #(
   parameter int NUM_LDO = rcr_pkg::NUM_LDO,
   parameter int ADDR_W  = 8
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [ADDR_W-1:0]   haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   input  wire logic                seq_apply,
   input  wire logic [2:0]          gpio_pin,
   output logic [NUM_LDO-1:0]       ldo_enable,
   output logic [NUM_LDO-1:0]       ldo_vsel_b,
   output logic [NUM_LDO-1:0]       ldo_pulldown_on,
   output logic                     vib_pmos_on,
   output logic                     vib_nmos_on
);
   localparam int IW = ADDR_W - 2;

   logic [7:0]            ctl_ff     [NUM_LDO];
   logic [7:0]            nxt_ctl    [NUM_LDO];
   logic [7:0]            vib_ff;
   logic [7:0]            nxt_vib;
   logic [NUM_LDO-1:0]    pd_on_ff;
   logic [NUM_LDO-1:0]    nxt_pd_on;
   logic [NUM_LDO-1:0]    wr_hit;
   logic [NUM_LDO-1:0]    en_upd;
   logic [NUM_LDO-1:0]    en_val;
   logic [NUM_LDO-1:0]    vs_upd;
   logic [NUM_LDO-1:0]    vs_val;
   logic                  wr_vib;
   logic                  wr_pend_ff;
   logic                  addr_ok_ff;
   logic [IW-1:0]         addr_ff;
   logic                  take;
   logic                  addr_ok;
   logic [7:0]            rd_idx;
   logic [31:0]           rdata_ff;
   logic [31:0]           nxt_rdata;
   logic                  ready_ff;
   logic [2:0]            gpio_meta_ff;
   logic [2:0]            gpio_sync_ff;
   logic [2:0]            gpio_prev_ff;
   logic [7:0]            ldo_idx    [NUM_LDO];

   assign ldo_idx[0] = rcr_pkg::IDX_REG8;
   assign ldo_idx[1] = rcr_pkg::IDX_REG9;
   assign ldo_idx[2] = rcr_pkg::IDX_REG10;
   assign ldo_idx[3] = rcr_pkg::IDX_REG11;

   // ----------------------------------------------------------------
   // gpio synchroniser and edge history
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_meta_ff <= 3'h0;
         gpio_sync_ff <= 3'h0;
      end else begin
         gpio_meta_ff <= gpio_pin;
         gpio_sync_ff <= gpio_meta_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_prev_ff <= 3'h0;
      end else begin
         gpio_prev_ff <= gpio_sync_ff;
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite address phase
   // ----------------------------------------------------------------
   assign take    = hsel && hready && htrans[1];
   assign addr_ok = (haddr[1:0] == 2'h0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ok_ff <= 1'b0;
         addr_ff    <= '0;
      end else if (take) begin
         wr_pend_ff <= hwrite;
         addr_ok_ff <= addr_ok;
         addr_ff    <= haddr[ADDR_W-1:2];
      end else if (hready) begin
         wr_pend_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // write decode, data phase
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_LDO; i++) begin
         wr_hit[i] = wr_pend_ff && addr_ok_ff &&
                     (ldo_idx[i] == {{(8-IW){1'b0}}, addr_ff});
      end
   end

   assign wr_vib = wr_pend_ff && addr_ok_ff &&
                   (rcr_pkg::IDX_VIB == {{(8-IW){1'b0}}, addr_ff});

   // ----------------------------------------------------------------
   // per-regulator gpio and sequencer decoders
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_LDO; g++) begin : g_ldo
      rcr_upd_if u_upd ();

      rcr_ldo_ctl u_ctl (
         .ctl       (ctl_ff[g]),
         .gpio_lvl  (gpio_sync_ff),
         .gpio_prv  (gpio_prev_ff),
         .seq_apply (seq_apply),
         .upd       (u_upd.src)
      );

      assign en_upd[g] = u_upd.en_upd;
      assign en_val[g] = u_upd.en_val;
      assign vs_upd[g] = u_upd.vs_upd;
      assign vs_val[g] = u_upd.vs_val;
   end

   // ----------------------------------------------------------------
   // next register values, hardware update wins over write
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_LDO; i++) begin
         nxt_ctl[i] = ctl_ff[i];
         if (wr_hit[i]) begin
            nxt_ctl[i] = hwdata[7:0]; // RULE7
         end
         if (en_upd[i]) begin
            nxt_ctl[i][rcr_pkg::BIT_EN] = en_val[i]; // RULE6
         end
         if (vs_upd[i]) begin
            nxt_ctl[i][rcr_pkg::BIT_VSEL] = vs_val[i]; // RULE2
         end
         nxt_pd_on[i] = !nxt_ctl[i][rcr_pkg::BIT_EN] &&
                        !nxt_ctl[i][rcr_pkg::BIT_PD_DIS]; // RULE5
      end
   end

   assign nxt_vib = wr_vib ? hwdata[7:0] : vib_ff; // RULE10

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_LDO; i++) begin
            ctl_ff[i] <= rcr_pkg::CTL_RST;
         end
      end else begin
         for (int i = 0; i < NUM_LDO; i++) begin
            ctl_ff[i] <= nxt_ctl[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vib_ff <= rcr_pkg::VIB_RST;
      end else begin
         vib_ff <= nxt_vib;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_on_ff <= '1;
      end else begin
         pd_on_ff <= nxt_pd_on;
      end
   end

   // ----------------------------------------------------------------
   // read data, sampled from next values so a preceding write shows
   // ----------------------------------------------------------------
   assign rd_idx = {{(8-IW){1'b0}}, haddr[ADDR_W-1:2]};

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (addr_ok) begin
         for (int i = 0; i < NUM_LDO; i++) begin
            if (rd_idx == ldo_idx[i]) begin
               nxt_rdata = {24'h00_0000, nxt_ctl[i]}; // RULE10
            end
         end
         if (rd_idx == rcr_pkg::IDX_VIB) begin
            nxt_rdata = {24'h00_0000, nxt_vib}; // RULE10
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_ff <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // ahb-lite wants hreadyout high through reset as well
         ready_ff <= 1'b1;
      end else begin
         ready_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // vibration motor driver
   // ----------------------------------------------------------------
   rcr_vib_drv u_vib (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .code       (vib_ff[rcr_pkg::VIB_CODE_HI:0]),
      .pmos_on_ff (vib_pmos_on),
      .nmos_on_ff (vib_nmos_on)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_LDO; i++) begin
         ldo_enable[i] = ctl_ff[i][rcr_pkg::BIT_EN]; // RULE7
         ldo_vsel_b[i] = ctl_ff[i][rcr_pkg::BIT_VSEL]; // RULE4
      end
   end

   assign ldo_pulldown_on = pd_on_ff;
   assign hreadyout       = ready_ff;
   assign hresp           = 1'b0;
   assign hrdata          = rdata_ff;

   // ----------------------------------------------------------------
   // checks per regulator
   // ----------------------------------------------------------------
   for (genvar a = 0; a < NUM_LDO; a++) begin : g_chk
      logic [1:0] es;
      logic [1:0] vs;
      assign es = ctl_ff[a][rcr_pkg::EN_SRC_HI:rcr_pkg::EN_SRC_LO];
      assign vs = ctl_ff[a][rcr_pkg::VS_SRC_HI:rcr_pkg::VS_SRC_LO];

      a_seq_target_apply: assert property (@(posedge hclk) // RULE1
         disable iff (!hresetn)
         seq_apply && es == rcr_pkg::SRC_SEQ |=>
            ldo_enable[a] == $past(ctl_ff[a][rcr_pkg::BIT_SEQ_TGT]))
         else $error("sequencer target not applied to enable");

      a_vsel_gpio_edge: assert property (@(posedge hclk) // RULE2
         disable iff (!hresetn)
         vs != rcr_pkg::SRC_SEQ &&
         rcr_pkg::src_bit(vs, gpio_sync_ff) !=
            rcr_pkg::src_bit(vs, gpio_prev_ff) |=>
            ldo_vsel_b[a] == !$past(rcr_pkg::src_bit(vs, gpio_sync_ff)))
         else $error("gpio edge did not pick voltage setting");

      a_seq_owns_enable: assert property (@(posedge hclk) // RULE3
         disable iff (!hresetn)
         es == rcr_pkg::SRC_SEQ && !seq_apply && !wr_hit[a] |=>
            $stable(ldo_enable[a]))
         else $error("enable moved while sequencer owns it");

      a_vsel_write: assert property (@(posedge hclk) // RULE4
         disable iff (!hresetn)
         wr_hit[a] && !vs_upd[a] |=>
            ldo_vsel_b[a] == $past(hwdata[rcr_pkg::BIT_VSEL]))
         else $error("voltage select write not applied at once");

      a_pulldown_state: assert property (@(posedge hclk) // RULE5
         disable iff (!hresetn)
         ldo_pulldown_on[a] ==
            (!ldo_enable[a] && !ctl_ff[a][rcr_pkg::BIT_PD_DIS]))
         else $error("pull-down state wrong");

      a_en_gpio_edge: assert property (@(posedge hclk) // RULE6
         disable iff (!hresetn)
         es != rcr_pkg::SRC_SEQ &&
         rcr_pkg::src_bit(es, gpio_sync_ff) !=
            rcr_pkg::src_bit(es, gpio_prev_ff) |=>
            ldo_enable[a] == $past(rcr_pkg::src_bit(es, gpio_sync_ff)))
         else $error("gpio edge did not switch enable");

      a_en_direct_write: assert property (@(posedge hclk) // RULE7
         disable iff (!hresetn)
         wr_hit[a] && !en_upd[a] |=>
            ldo_enable[a] == $past(hwdata[rcr_pkg::BIT_EN]))
         else $error("enable write not applied");

      a_enable_hold: assert property (@(posedge hclk) // RULE3
         disable iff (!hresetn)
         es != rcr_pkg::SRC_SEQ && !wr_hit[a] &&
         rcr_pkg::src_bit(es, gpio_sync_ff) ==
            rcr_pkg::src_bit(es, gpio_prev_ff) |=>
            $stable(ldo_enable[a]))
         else $error("gpio owned enable moved without an edge");

      a_vsel_hold: assert property (@(posedge hclk) // RULE4
         disable iff (!hresetn)
         !wr_hit[a] && (vs == rcr_pkg::SRC_SEQ ||
            rcr_pkg::src_bit(vs, gpio_sync_ff) ==
               rcr_pkg::src_bit(vs, gpio_prev_ff)) |=>
            $stable(ldo_vsel_b[a]))
         else $error("voltage select moved without edge or write");

      a_pulldown_write: assert property (@(posedge hclk) // RULE5
         disable iff (!hresetn)
         wr_hit[a] && !en_upd[a] |=>
            ldo_pulldown_on[a] ==
               (!$past(hwdata[rcr_pkg::BIT_EN]) &&
                !$past(hwdata[rcr_pkg::BIT_PD_DIS])))
         else $error("pull-down does not follow written byte");

      a_ctl_readback: assert property (@(posedge hclk) // RULE10
         disable iff (!hresetn)
         wr_hit[a] && !en_upd[a] && !vs_upd[a] |=>
            ctl_ff[a] == $past(hwdata[7:0]))
         else $error("control byte lost written value");
   end

   a_vib_readback: assert property (@(posedge hclk) // RULE10
      disable iff (!hresetn)
      wr_vib |=> vib_ff == $past(hwdata[7:0]))
      else $error("vibration register lost written value");
endmodule // rcr_regs

// ### tb/regulator_control_regs_8_to_11_tb.sv
// Purpose: self-checking bench for the regulator control register bank
// Assumes: zero-wait ahb-lite slave, gpio pins sampled through syncs
// Notes:   reads are checked from a queue by a separate monitor
module regulator_control_regs_8_to_11_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        seq_apply;
   logic [2:0]  gpio_pin;
   logic [3:0]  ldo_enable;
   logic [3:0]  ldo_vsel_b;
   logic [3:0]  ldo_pulldown_on;
   logic        vib_pmos_on;
   logic        vib_nmos_on;
   logic        rd_dp;
   logic [31:0] exp_q[$];
   logic [7:0]  v;
   logic [1:0]  sc;
   logic [5:0]  c;
   logic [31:0] np;
   logic [31:0] nn;
   logic [7:0]  sw[3]  = '{8'h80, 8'h01, 8'h03};
   logic [7:0]  sr[3]  = '{8'h81, 8'h00, 8'h03};
   logic [5:0]  vc[3]  = '{6'h00, 6'h01, 6'h3F};
   int          fail_count;
   int          n_compared;
   int          cyc;
   int          seed;
   int          i;
   int          j;

   rcr_regs rcr_regs_inst (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hreadyout),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .hrdata          (hrdata),
      .seq_apply       (seq_apply),
      .gpio_pin        (gpio_pin),
      .ldo_enable      (ldo_enable),
      .ldo_vsel_b      (ldo_vsel_b),
      .ldo_pulldown_on (ldo_pulldown_on),
      .vib_pmos_on     (vib_pmos_on),
      .vib_nmos_on     (vib_nmos_on)
   );

   always #10 hclk = ~hclk;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] ra(input int k);
      logic [7:0] x;
      x = rcr_pkg::IDX_REG8 + 8'(k);
      return {x[5:0], 2'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] ex);
      n_compared++;
      if (seen !== ex) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // single word transfer; for a read d is the expected byte
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
      logic [31:0] r;
      r = $random(seed);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {r[31:8], d};
      if (!w) begin
         exp_q.push_back({24'h0, d});
         rd_dp <= 1'b1;
      end
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask

   task automatic pulse();
      @(posedge hclk);
      seq_apply <= 1'b1;
      @(posedge hclk);
      seq_apply <= 1'b0;
      @(negedge hclk);
   endtask

   always @(posedge hclk) begin
      if (rd_dp && hreadyout === 1'b1) begin
         chk("hrdata", hrdata, exp_q.pop_front());
         chk("hresp", 32'(hresp), 32'h0);
      end
   end

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         finish_test();
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      seq_apply = 1'b0;
      gpio_pin = 3'h0;
      rd_dp = 1'b0;
      seed = 32'hC392;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk("pd_rst", 32'(ldo_pulldown_on), 32'hF);
      chk("nmos_rst", 32'(vib_nmos_on), 32'h1);
      chk("pmos_rst", 32'(vib_pmos_on), 32'h0);
      for (i = 0; i < 5; i++) bus(ra(i), 1'b0, 8'h00);
      // misaligned and unmapped places
      bus(8'hB5, 1'b1, 8'hFF);
      bus(8'hB5, 1'b0, 8'h00);
      bus(8'hC8, 1'b0, 8'h00);
      bus(ra(0), 1'b0, 8'h00);
      // readback and direct effect of each control byte
      for (i = 0; i < 5; i++) begin
         v = 8'($random(seed));
         bus(ra(i), 1'b1, v);
         bus(ra(i), 1'b0, v);
         @(negedge hclk);
         if (i < 4) begin
            chk("en", 32'(ldo_enable[i]), 32'(v[0]));
            chk("vsel", 32'(ldo_vsel_b[i]), 32'(v[4]));
            chk("pd", 32'(ldo_pulldown_on[i]), 32'(!v[0] && !v[3]));
         end
      end
      // gpio control, each source code on its own regulator
      bus(ra(0), 1'b1, 8'h00);
      for (i = 1; i < 4; i++) begin
         sc = 2'(i);
         bus(ra(i), 1'b1, {1'b0, sc, 1'b1, 1'b0, sc, 1'b0});
         gpio_pin[i-1] <= 1'b1;
         repeat (6) @(negedge hclk);
         chk("g_en", 32'(ldo_enable[i]), 32'h1);
         chk("g_vs", 32'(ldo_vsel_b[i]), 32'h0);
         chk("g_pd", 32'(ldo_pulldown_on[i]), 32'h0);
         @(posedge hclk);
         gpio_pin[i-1] <= 1'b0;
         repeat (6) @(negedge hclk);
         chk("g_en", 32'(ldo_enable[i]), 32'h0);
         chk("g_vs", 32'(ldo_vsel_b[i]), 32'h1);
         chk("g_pd", 32'(ldo_pulldown_on[i]), 32'h1);
         chk("g_sq", 32'(ldo_enable[0]), 32'h0);
      end
      // sequencer run, ignored once a gpio owns the enable
      for (i = 0; i < 4; i++) begin
         for (j = 0; j < 3; j++) begin
            bus(ra(i), 1'b1, sw[j]);
            pulse();
            chk("seq", 32'(ldo_enable[i]), 32'(sr[j][0]));
            bus(ra(i), 1'b0, sr[j]);
         end
      end
      // vibration duty over one full period
      for (j = 0; j < 4; j++) begin
         c = (j == 3) ? 6'($random(seed)) : vc[j];
         bus(ra(4), 1'b1, {2'h3, c});
         repeat (70) @(negedge hclk);
         np = 32'h0;
         nn = 32'h0;
         repeat (63) begin
            @(negedge hclk);
            np = np + 32'(vib_pmos_on);
            nn = nn + 32'(vib_nmos_on);
         end
         chk("pmos_n", np, 32'(c));
         chk("nmos_n", nn, 32'd63 - 32'(c));
      end
      bus(ra(4), 1'b0, {2'h3, c});
      repeat (2) @(posedge hclk);
      finish_test();
   end
endmodule // regulator_control_regs_8_to_11_tb
